// ===== logic/csp_serial_port.sv
// Frame-sync and shift-clock control of a codec serial port, with register port.
// Assumes pins arrive asynchronous to i_clock; register port is on i_clock.
// Function
// - Indicator select 0 drives the primary-low, secondary-high communication flag.
// - Indicator select 1 drives the general output bit instead.
// - Receiving and transmitting begin when frame sync goes low.
// - Master generates frame sync, low while data shifts.
// - Delayed sync output feeds a chained slave, same duration as frame sync.
// - Master/slave select high means master, low means slave.
// - Master shift clock is frame rate times 256, or 512 for wide cascades.
// - Power-down pin low stops the serial interface and its clocks.
// - Power-down clears counters and frame and clock state, registers are kept.
// - Reset loads every register with its default.
// - Secondary request pin asks for a secondary interval; honoured in master mode only, slave follows the frame sync pin.
// - Input bits sampled on falling shift clock inside the frame only.
// - Output bits driven on rising shift clock, high impedance outside the frame.
// - Each transfer interval lasts sixteen shift clocks from frame sync falling.
// - Secondary sync follows primary by 128 shift clocks, or 256 for wide cascades.
`timescale 1ns/100ps
module csp_serial_port
  import csp_pkg::*;
#(
  parameter int SCLK_HALF = CSP_SCLK_HALF_CYC
) (
  input wire logic i_clock,
  input wire logic i_nrst,
  input wire logic [7:0] i_addr,
  input wire logic [31:0] i_wdata,
  input wire logic i_wr,
  input wire logic i_rd,
  output logic [31:0] o_rdata,
  input wire logic i_master_sel,
  input wire logic i_power_down_pin_n,
  input wire logic i_secondary_request_pin,
  input wire logic i_iface_mode_sel_lo,
  input wire logic i_iface_mode_sel_hi,
  input wire logic i_frame_sync,
  output logic o_frame_sync,
  output logic o_frame_sync_oe_n,
  input wire logic i_sclk,
  output logic o_sclk,
  output logic o_sclk_oe_n,
  input wire logic i_din,
  output logic o_dout,
  output logic o_dout_oe_n,
  output logic o_delayed_sync_out,
  output logic o_indicator
);

  // Two-flop synchronisers; stage 1 read only by stage 2
  localparam int NSYNC = 8;
  logic [NSYNC-1:0] sync1_q;
  logic [NSYNC-1:0] sync2_q;
  logic [NSYNC-1:0] pins;
  assign pins = {i_master_sel, i_power_down_pin_n, i_secondary_request_pin, i_iface_mode_sel_lo,
                 i_iface_mode_sel_hi, i_frame_sync, i_sclk, i_din};
  always_ff @(posedge i_clock or negedge i_nrst) begin
    if (!i_nrst) begin
      sync1_q <= 8'h5c;
      sync2_q <= 8'h5c;
    end else begin
      sync1_q <= pins;
      sync2_q <= sync1_q;
    end
  end
  logic master;
  logic pd;
  logic req_s;
  logic fs_s;
  logic sclk_s;
  logic din_s;
  assign master = sync2_q[7];
  assign pd = ~sync2_q[6];
  assign req_s = sync2_q[5];
  assign fs_s = sync2_q[2];
  assign sclk_s = sync2_q[1];
  assign din_s = sync2_q[0];

  // Edge history of synchronised pins
  logic sclk_d_q;
  logic fs_d_q;
  logic req_d_q;
  always_ff @(posedge i_clock or negedge i_nrst) begin
    if (!i_nrst) begin
      sclk_d_q <= 1'b0;
      fs_d_q <= 1'b1;
      req_d_q <= 1'b0;
    end else begin
      sclk_d_q <= sclk_s;
      fs_d_q <= fs_s;
      req_d_q <= req_s;
    end
  end

  // Registers
  logic [31:0] ctrl_q;
  logic [15:0] tx_pri_q;
  logic [15:0] tx_sec_q;
  logic [15:0] rx_pri_q;
  logic [15:0] rx_sec_q;
  logic [31:0] rdata_q;
  logic wide;
  assign wide = ctrl_q[CSP_CTRL_WIDE];
  always_ff @(posedge i_clock or negedge i_nrst) begin
    if (!i_nrst) begin
      ctrl_q <= CSP_CTRL_RST;
      tx_pri_q <= CSP_WORD_RST;
      tx_sec_q <= CSP_WORD_RST;
    end else if (i_wr) begin
      // Power-down does not touch these
      unique case (i_addr)
        CSP_OFS_CTRL: ctrl_q <= {25'h0, i_wdata[CSP_CTRL_WIDE], 1'b0, i_wdata[4:0]};
        CSP_OFS_TX_PRI: tx_pri_q <= i_wdata[15:0];
        CSP_OFS_TX_SEC: tx_sec_q <= i_wdata[15:0];
        default: ;
      endcase
    end
  end

  // Master shift clock divider
  logic [7:0] div_q;
  logic sclk_q;
  logic div_tick;
  assign div_tick = (div_q == 8'(SCLK_HALF - 1));
  always_ff @(posedge i_clock or negedge i_nrst) begin
    if (!i_nrst) begin
      div_q <= 8'h00;
      sclk_q <= 1'b0;
    end else if (pd || !master) begin
      div_q <= 8'h00;
      sclk_q <= 1'b0;
    end else if (div_tick) begin
      div_q <= 8'h00;
      sclk_q <= ~sclk_q;
    end else begin
      div_q <= div_q + 8'h01;
    end
  end

  // Shift clock edges: own divider as master, sampled pin as slave
  logic rise_ev;
  logic fall_ev;
  assign rise_ev = !pd && (master ? (div_tick && !sclk_q) : (sclk_s && !sclk_d_q));
  assign fall_ev = !pd && (master ? (div_tick && sclk_q) : (!sclk_s && sclk_d_q));

  // Frame period and secondary request
  logic [9:0] per_q;
  logic [9:0] period;
  logic [9:0] sec_ofs;
  logic sec_pend_q;
  logic in_frame_q;
  logic frame_sec_q;
  logic start_pri;
  logic start_sec;
  logic slave_start;
  assign period = wide ? CSP_PERIOD_WIDE : CSP_PERIOD_NARROW;
  assign sec_ofs = wide ? CSP_SEC_WIDE : CSP_SEC_NARROW;
  assign slave_start = !master && !pd && !fs_s && fs_d_q;
  assign start_pri = master ? (rise_ev && per_q == 10'h000) : (slave_start && per_q < (sec_ofs >> 1));
  assign start_sec = master ? (rise_ev && per_q == sec_ofs && sec_pend_q)
                            : (slave_start && per_q >= (sec_ofs >> 1));
  always_ff @(posedge i_clock or negedge i_nrst) begin
    if (!i_nrst) begin
      per_q <= 10'h000;
    end else if (pd) begin
      per_q <= 10'h000;
    end else if (slave_start && per_q < (sec_ofs >> 1)) begin
      per_q <= 10'h000;
    end else if (rise_ev) begin
      if (master) begin
        per_q <= (per_q == period - 10'h001) ? 10'h000 : per_q + 10'h001;
      end else if (per_q != 10'h3ff) begin
        per_q <= per_q + 10'h001;
      end
    end
  end

  // Pending secondary request; a new request wins over the clear
  always_ff @(posedge i_clock or negedge i_nrst) begin
    if (!i_nrst) begin
      sec_pend_q <= 1'b0;
    end else if ((req_s && !req_d_q) || (i_wr && i_addr == CSP_OFS_CTRL && i_wdata[CSP_CTRL_SEC_REQ])) begin
      sec_pend_q <= 1'b1;
    end else if (start_sec) begin
      sec_pend_q <= 1'b0;
    end
  end

  // Transfer interval: sixteen rising edges from frame start
  logic [4:0] tx_cnt_q;
  logic [15:0] tx_sh_q;
  logic dout_q;
  logic fs_out_q;
  logic chain_q;
  logic [4:0] chain_cnt_q;
  logic fsd_q;
  logic comm_flag_q;
  logic frame_end;
  assign frame_end = in_frame_q && ((rise_ev && tx_cnt_q == 5'(CSP_WORD_BITS - 1)) || (!master && fs_s));
  always_ff @(posedge i_clock or negedge i_nrst) begin
    if (!i_nrst) begin
      in_frame_q <= 1'b0;
      frame_sec_q <= 1'b0;
      tx_cnt_q <= 5'h00;
      tx_sh_q <= CSP_WORD_RST;
      dout_q <= 1'b0;
      fs_out_q <= 1'b1;
      comm_flag_q <= 1'b0;
    end else if (pd) begin
      in_frame_q <= 1'b0;
      tx_cnt_q <= 5'h00;
      fs_out_q <= 1'b1;
    end else if (start_pri || start_sec) begin
      in_frame_q <= 1'b1;
      frame_sec_q <= start_sec;
      comm_flag_q <= start_sec;
      tx_cnt_q <= 5'h00;
      tx_sh_q <= {start_sec ? tx_sec_q[14:0] : tx_pri_q[14:0], 1'b0};
      dout_q <= start_sec ? tx_sec_q[15] : tx_pri_q[15];
      fs_out_q <= 1'b0;
    end else if (frame_end) begin
      in_frame_q <= 1'b0;
      fs_out_q <= 1'b1;
    end else if (in_frame_q && rise_ev) begin
      tx_cnt_q <= tx_cnt_q + 5'h01;
      dout_q <= tx_sh_q[15];
      tx_sh_q <= {tx_sh_q[14:0], 1'b0};
    end
  end

  // Delayed sync for the next device in the chain
  always_ff @(posedge i_clock or negedge i_nrst) begin
    if (!i_nrst) begin
      chain_q <= 1'b0;
      chain_cnt_q <= 5'h00;
      fsd_q <= 1'b1;
    end else if (pd) begin
      chain_q <= 1'b0;
      chain_cnt_q <= 5'h00;
      fsd_q <= 1'b1;
    end else if (frame_end) begin
      chain_q <= 1'b1;
      chain_cnt_q <= 5'h00;
      fsd_q <= 1'b0;
    end else if (chain_q && rise_ev) begin
      if (chain_cnt_q == 5'(CSP_WORD_BITS - 1)) begin
        chain_q <= 1'b0;
        fsd_q <= 1'b1;
      end else begin
        chain_cnt_q <= chain_cnt_q + 5'h01;
      end
    end
  end

  // Own clock reaches the pin a cycle late and data lags two more, so master waits to hit the pin's fall
  logic [2:0] rx_pipe_q;
  logic rx_take;
  always_ff @(posedge i_clock or negedge i_nrst) begin
    if (!i_nrst) rx_pipe_q <= 3'h0;
    else rx_pipe_q <= {rx_pipe_q[1:0], master && in_frame_q && fall_ev};
  end
  assign rx_take = master ? rx_pipe_q[2] : (in_frame_q && fall_ev);

  // Receive on falling edges inside the frame only
  logic [4:0] rx_cnt_q;
  logic [15:0] rx_sh_q;
  always_ff @(posedge i_clock or negedge i_nrst) begin
    if (!i_nrst) begin
      rx_cnt_q <= 5'h00;
      rx_sh_q <= CSP_WORD_RST;
      rx_pri_q <= CSP_WORD_RST;
      rx_sec_q <= CSP_WORD_RST;
    end else if (pd || start_pri || start_sec) begin
      rx_cnt_q <= 5'h00;
    end else if (rx_take && rx_cnt_q < 5'(CSP_WORD_BITS)) begin
      rx_sh_q <= {rx_sh_q[14:0], din_s};
      rx_cnt_q <= rx_cnt_q + 5'h01;
      if (rx_cnt_q == 5'(CSP_WORD_BITS - 1)) begin
        if (frame_sec_q) begin
          rx_sec_q <= {rx_sh_q[14:0], din_s};
        end else begin
          rx_pri_q <= {rx_sh_q[14:0], din_s};
        end
      end
    end
  end

  // Pin drivers, all registered
  always_ff @(posedge i_clock or negedge i_nrst) begin
    if (!i_nrst) begin
      o_frame_sync <= 1'b1;
      o_frame_sync_oe_n <= 1'b1;
      o_sclk <= 1'b0;
      o_sclk_oe_n <= 1'b1;
      o_dout <= 1'b0;
      o_dout_oe_n <= 1'b1;
      o_delayed_sync_out <= 1'b1;
      o_indicator <= 1'b0;
    end else begin
      o_frame_sync <= fs_out_q;
      o_frame_sync_oe_n <= !(master && !pd);
      o_sclk <= sclk_q;
      o_sclk_oe_n <= !(master && !pd);
      o_dout <= dout_q;
      // Follows frame sync exactly, so data is never driven without a frame
      o_dout_oe_n <= !in_frame_q;
      o_delayed_sync_out <= fsd_q;
      o_indicator <= ctrl_q[CSP_CTRL_IND_SEL] ? ctrl_q[CSP_CTRL_GP_OUT] : comm_flag_q;
    end
  end

  // Register read, answered in the next cycle only
  always_ff @(posedge i_clock or negedge i_nrst) begin
    if (!i_nrst) begin
      rdata_q <= 32'h0000_0000;
    end else if (i_rd) begin
      unique case (i_addr)
        CSP_OFS_CTRL: rdata_q <= ctrl_q;
        // Mode pins shown as strapped by the far party
        CSP_OFS_STATUS: rdata_q <= {24'h0, sync2_q[3], sync2_q[4], fsd_q, pd, sec_pend_q,
                                    comm_flag_q, in_frame_q, master};
        CSP_OFS_TX_PRI: rdata_q <= {16'h0000, tx_pri_q};
        CSP_OFS_TX_SEC: rdata_q <= {16'h0000, tx_sec_q};
        CSP_OFS_RX_PRI: rdata_q <= {16'h0000, rx_pri_q};
        CSP_OFS_RX_SEC: rdata_q <= {16'h0000, rx_sec_q};
        default: rdata_q <= 32'h0000_0000;
      endcase
    end else begin
      rdata_q <= 32'h0000_0000;
    end
  end
  assign o_rdata = rdata_q;

endmodule : csp_serial_port

// ===== logic/csp_pkg.sv
// Constants for the codec serial-port framing block.
// Assumes a single 20 MHz system clock; offsets are byte addresses.
package csp_pkg;
  // Register map
  localparam logic [7:0] CSP_OFS_CTRL = 8'h00;
  localparam logic [7:0] CSP_OFS_STATUS = 8'h04;
  localparam logic [7:0] CSP_OFS_TX_PRI = 8'h08;
  localparam logic [7:0] CSP_OFS_TX_SEC = 8'h0c;
  localparam logic [7:0] CSP_OFS_RX_PRI = 8'h10;
  localparam logic [7:0] CSP_OFS_RX_SEC = 8'h14;
  // Control field positions
  localparam int CSP_CTRL_GP_OUT = 3;
  localparam int CSP_CTRL_IND_SEL = 4;
  localparam int CSP_CTRL_SEC_REQ = 5;
  localparam int CSP_CTRL_WIDE = 6;
  // Reset values
  localparam logic [31:0] CSP_CTRL_RST = 32'h0000_0000;
  localparam logic [15:0] CSP_WORD_RST = 16'h0000;
  // Framing figures, in shift clocks
  localparam int CSP_WORD_BITS = 16;
  localparam logic [9:0] CSP_PERIOD_NARROW = 10'h100;
  localparam logic [9:0] CSP_PERIOD_WIDE = 10'h200;
  localparam logic [9:0] CSP_SEC_NARROW = 10'h080;
  localparam logic [9:0] CSP_SEC_WIDE = 10'h100;
  // Shift clock timing in master mode
  localparam int CSP_CLK_PERIOD_NS = 50;
  localparam int CSP_SCLK_PERIOD_NS = 400;
  localparam int CSP_SCLK_HALF_CYC = (CSP_SCLK_PERIOD_NS + 2 * CSP_CLK_PERIOD_NS - 1) / (2 * CSP_CLK_PERIOD_NS);
endpackage : csp_pkg

// ===== verification/csp_props.sv
// Checker on the framing pins of the serial port.
// Assumes the master shift clock spends SCLK_HALF system cycles in each half.
`timescale 1ns/100ps
module csp_props #(
  parameter int SCLK_HALF = 4
) (
  input wire logic i_clock,
  input wire logic i_nrst,
  input wire logic i_master_sel,
  input wire logic i_power_down_pin_n,
  input wire logic o_frame_sync,
  input wire logic o_frame_sync_oe_n,
  input wire logic o_sclk,
  input wire logic o_sclk_oe_n,
  input wire logic o_dout,
  input wire logic o_dout_oe_n,
  input wire logic o_delayed_sync_out
);
  default clocking cb @(posedge i_clock); endclocking
  default disable iff (!i_nrst);
  logic [9:0] fs_cnt_q;
  logic [9:0] fsd_cnt_q;
  logic [9:0] half_cnt_q;
  logic sclk_prev_q;
  logic seen_q;
  always_ff @(posedge i_clock or negedge i_nrst) begin
    if (!i_nrst) fs_cnt_q <= 10'h000;
    else fs_cnt_q <= o_frame_sync ? 10'h000 : fs_cnt_q + 10'h001;
  end
  always_ff @(posedge i_clock or negedge i_nrst) begin
    if (!i_nrst) fsd_cnt_q <= 10'h000;
    else fsd_cnt_q <= o_delayed_sync_out ? 10'h000 : fsd_cnt_q + 10'h001;
  end
  // First toggle after a stop has no fixed phase, so it only arms the check
  always_ff @(posedge i_clock or negedge i_nrst) begin
    if (!i_nrst) begin
      sclk_prev_q <= 1'b0;
      half_cnt_q <= 10'h000;
      seen_q <= 1'b0;
    end else begin
      sclk_prev_q <= o_sclk;
      half_cnt_q <= (o_sclk != sclk_prev_q) ? 10'h000 : half_cnt_q + 10'h001;
      seen_q <= i_power_down_pin_n && !o_sclk_oe_n && (seen_q || o_sclk != sclk_prev_q);
    end
  end
  property p_reset_vals;
    disable iff (1'b0) !i_nrst |-> o_frame_sync && o_frame_sync_oe_n && o_dout_oe_n && o_delayed_sync_out;
  endproperty
  a_reset_vals: assert property (p_reset_vals) else $error("pins not idle in reset");
  property p_slave_release;
    !i_master_sel [*6] |=> o_frame_sync_oe_n && o_sclk_oe_n;
  endproperty
  a_slave_release: assert property (p_slave_release) else $error("slave still drives pins");
  property p_fs_len;
    $rose(o_frame_sync) && !o_frame_sync_oe_n |-> fs_cnt_q == 10'(32 * SCLK_HALF);
  endproperty
  a_fs_len: assert property (p_fs_len) else $error("frame sync low time wrong");
  property p_dout_window;
    !o_frame_sync_oe_n |-> o_dout_oe_n == o_frame_sync;
  endproperty
  a_dout_window: assert property (p_dout_window) else $error("data drive outside frame");
  property p_dout_edge;
    $changed(o_dout) && !o_dout_oe_n && !$past(o_dout_oe_n) && !o_sclk_oe_n |->
      $rose(o_sclk) || ($past(o_sclk) && !$past(o_sclk, 2));
  endproperty
  a_dout_edge: assert property (p_dout_edge) else $error("data changed off rising shift clock");
  property p_sclk_half;
    $changed(o_sclk) && seen_q && !o_sclk_oe_n |-> half_cnt_q == 10'(SCLK_HALF - 1);
  endproperty
  a_sclk_half: assert property (p_sclk_half) else $error("shift clock half period wrong");
  property p_pd_quiet;
    !i_power_down_pin_n [*6] |=> o_frame_sync_oe_n && o_dout_oe_n && $stable(o_sclk);
  endproperty
  a_pd_quiet: assert property (p_pd_quiet) else $error("port active in power down");
  property p_fsd_len;
    $rose(o_delayed_sync_out) && !o_frame_sync_oe_n |-> fsd_cnt_q == 10'(32 * SCLK_HALF);
  endproperty
  a_fsd_len: assert property (p_fsd_len) else $error("delayed sync length wrong");
endmodule : csp_props
bind csp_serial_port csp_props #(.SCLK_HALF(SCLK_HALF)) u_props (.i_clock(i_clock), .i_nrst(i_nrst),
  .i_master_sel(i_master_sel), .i_power_down_pin_n(i_power_down_pin_n), .o_frame_sync(o_frame_sync),
  .o_frame_sync_oe_n(o_frame_sync_oe_n), .o_sclk(o_sclk), .o_sclk_oe_n(o_sclk_oe_n), .o_dout(o_dout),
  .o_dout_oe_n(o_dout_oe_n), .o_delayed_sync_out(o_delayed_sync_out));

// ===== verification/csp_host_model.sv
// Host model: serial input words, and shift clock plus frame sync in slave mode.
// Assumes the bench resolves the shared pins from both output enables.
`timescale 1ns/100ps
module csp_host_model #(
  parameter logic [15:0] WORD = 16'h3c5a
) (
  input wire logic i_slave,
  input wire logic i_sclk,
  input wire logic i_fs,
  output logic o_sclk,
  output logic o_fs,
  output logic o_din
);
  int idx = 15;
  bit busy = 1'b0;
  logic [7:0] cnt = 8'h00;
  initial begin
    o_sclk = 1'b0;
    o_fs = 1'b1;
    o_din = 1'b0;
  end
  always #200 o_sclk = i_slave ? ~o_sclk : 1'b0;
  always @(posedge o_sclk) begin
    cnt <= cnt + 8'h01;
    o_fs <= cnt >= 8'h10;
  end
  // Late change keeps the bit steady across the sampling fall
  always @(posedge i_sclk) begin
    #60;
    if (!i_fs) begin
      idx = busy ? ((idx > 0) ? idx - 1 : 0) : 15;
      busy = 1'b1;
      o_din = WORD[idx];
    end else begin
      busy = 1'b0;
      o_din = ~o_din;
    end
  end
endmodule : csp_host_model

// ===== verification/tb.sv
// Self-checking bench for the codec serial-port framing block.
// Assumes the host model on the serial pins and a 50 ns system clock.
`timescale 1ns/100ps
module tb;
  import csp_pkg::*;
  localparam int HALF = 4;
  localparam int FRAME_NS = 512 * HALF * 50;
  logic clk = 1'b0;
  logic nrst = 1'b1;
  logic [7:0] addr = 8'h00;
  logic [31:0] wdata = 32'h0000_0000;
  logic wr = 1'b0;
  logic rd = 1'b0;
  logic ms = 1'b1;
  logic pd_n = 1'b1;
  logic sreq = 1'b0;
  logic [31:0] rdata;
  logic [31:0] got;
  logic fs_o, fs_oe_n, sclk_o, sclk_oe_n, dout, dout_oe_n, delayed_sync_out, ind, p_sclk, p_fs, din;
  wire fs_w = fs_oe_n ? p_fs : fs_o;
  wire sclk_w = sclk_oe_n ? p_sclk : sclk_o;
  int failures = 0;
  int n_tests = 0;
  int cyc = 0;
  time t0, t1, t2;
  always #25 clk = ~clk;
  csp_serial_port #(.SCLK_HALF(HALF)) dut (.i_clock(clk), .i_nrst(nrst), .i_addr(addr), .i_wdata(wdata),
    .i_wr(wr), .i_rd(rd), .o_rdata(rdata), .i_master_sel(ms), .i_power_down_pin_n(pd_n),
    .i_secondary_request_pin(sreq), .i_iface_mode_sel_lo(1'b0), .i_iface_mode_sel_hi(1'b1),
    .i_frame_sync(fs_w), .o_frame_sync(fs_o), .o_frame_sync_oe_n(fs_oe_n), .i_sclk(sclk_w), .o_sclk(sclk_o),
    .o_sclk_oe_n(sclk_oe_n), .i_din(din), .o_dout(dout), .o_dout_oe_n(dout_oe_n), .o_delayed_sync_out(delayed_sync_out),
    .o_indicator(ind));
  csp_host_model host (.i_slave(!ms), .i_sclk(sclk_w), .i_fs(fs_w), .o_sclk(p_sclk), .o_fs(p_fs), .o_din(din));
  task automatic give_verdict;
    if (failures == 0 && n_tests > 0) $display("No errors found");
    else $display("Errors were found");
    $finish;
  endtask : give_verdict
  task automatic chk(input string what, input logic [31:0] seen, input logic [31:0] exp);
    n_tests++;
    if (seen !== exp) begin
      failures++;
      $display("wrong value %s expected %h seen %h", what, exp, seen);
    end
  endtask : chk
  task automatic wr_reg(input logic [7:0] a, input logic [31:0] d);
    @(posedge clk);
    addr <= a;
    wdata <= d;
    wr <= 1'b1;
    @(posedge clk);
    wr <= 1'b0;
  endtask : wr_reg
  task automatic rd_reg(input logic [7:0] a, output logic [31:0] d);
    @(posedge clk);
    addr <= a;
    rd <= 1'b1;
    @(posedge clk);
    rd <= 1'b0;
    @(negedge clk);
    d = rdata;
  endtask : rd_reg
  task automatic wait_fall(output time t);
    for (int n = 0; n < 5000 && fs_w !== 1'b1; n++) @(posedge clk);
    for (int n = 0; n < 5000 && fs_w !== 1'b0; n++) @(posedge clk);
    t = $time;
  endtask : wait_fall
  task automatic t_regs;
    rd_reg(CSP_OFS_CTRL, got);
    chk("ctrl reset", got, CSP_CTRL_RST);
    rd_reg(CSP_OFS_TX_PRI, got);
    chk("tx reset", got, {16'h0000, CSP_WORD_RST});
    rd_reg(8'h20, got);
    chk("unmapped read", got, 32'h0000_0000);
    rd_reg(CSP_OFS_STATUS, got);
    chk("mode straps", {24'h0, got[7:6], 5'h00, got[0]}, 32'h0000_0081);
  endtask : t_regs
  task automatic t_frame;
    wr_reg(CSP_OFS_TX_PRI, 32'h0000_a5c3);
    wr_reg(CSP_OFS_RX_PRI, 32'h0000_ffff);
    wait_fall(t0);
    for (int i = 15; i >= 0; i--) begin
      @(negedge sclk_w);
      got[i] = dout;
    end
    chk("dout word", {16'h0000, got[15:0]}, 32'h0000_a5c3);
    chk("frame held", {31'h0, fs_w}, 32'h0000_0000);
    @(posedge sclk_w);
    #60;
    chk("frame end", {31'h0, fs_w}, 32'h0000_0001);
    wait_fall(t1);
    chk("frame period", 32'(t1 - t0), 32'(FRAME_NS));
    rd_reg(CSP_OFS_RX_PRI, got);
    chk("rx word", got, 32'h0000_3c5a);
  endtask : t_frame
  task automatic t_secondary;
    for (int k = 0; k < 2; k++) begin
      wait_fall(t0);
      if (k == 0) wr_reg(CSP_OFS_CTRL, 32'h0000_0020);
      else sreq <= 1'b1;
      wait_fall(t1);
      chk("secondary offset", 32'(t1 - t0), 32'(FRAME_NS / 2));
      repeat (8) @(posedge clk);
      chk("flag secondary", {31'h0, ind}, 32'h0000_0001);
      sreq <= 1'b0;
    end
  endtask : t_secondary
  task automatic t_wide;
    wr_reg(CSP_OFS_CTRL, 32'h0000_0040);
    wait_fall(t0);
    wait_fall(t0);
    repeat (8) @(posedge clk);
    chk("flag primary", {31'h0, ind}, 32'h0000_0000);
    wr_reg(CSP_OFS_CTRL, 32'h0000_0060);
    wait_fall(t1);
    wait_fall(t2);
    chk("wide offset", 32'(t1 - t0), 32'(FRAME_NS));
    chk("wide period", 32'(t2 - t0), 32'(2 * FRAME_NS));
  endtask : t_wide
  task automatic t_ind;
    wr_reg(CSP_OFS_CTRL, 32'h0000_0018);
    repeat (3) @(posedge clk);
    chk("flag gp high", {31'h0, ind}, 32'h0000_0001);
    wr_reg(CSP_OFS_CTRL, 32'h0000_0010);
    repeat (3) @(posedge clk);
    chk("flag gp low", {31'h0, ind}, 32'h0000_0000);
  endtask : t_ind
  task automatic t_pd;
    wr_reg(CSP_OFS_TX_PRI, 32'h0000_1234);
    wait_fall(t0);
    repeat (140) @(posedge clk);
    pd_n <= 1'b0;
    repeat (40) @(posedge clk);
    chk("pd fs released", {31'h0, fs_oe_n}, 32'h0000_0001);
    pd_n <= 1'b1;
    rd_reg(CSP_OFS_TX_PRI, got);
    chk("tx kept", got, 32'h0000_1234);
    @(negedge clk);
    chk("rdata one cycle", rdata, 32'h0000_0000);
    wait_fall(t0);
    wait_fall(t1);
    chk("period after pd", 32'(t1 - t0), 32'(FRAME_NS));
  endtask : t_pd
  task automatic t_slave;
    ms <= 1'b0;
    repeat (10) @(posedge clk);
    chk("slave pins off", {30'h0, fs_oe_n, sclk_oe_n}, 32'h0000_0003);
    wait_fall(t0);
    for (int n = 0; n < 400 && delayed_sync_out !== 1'b0; n++) @(posedge clk);
    chk("slave delayed sync", {31'h0, delayed_sync_out}, 32'h0000_0000);
  endtask : t_slave
  initial begin
    nrst <= 1'b0;
    repeat (6) @(posedge clk);
    nrst <= 1'b1;
    t_regs();
    t_frame();
    t_secondary();
    t_wide();
    t_ind();
    t_pd();
    t_slave();
    give_verdict();
  end
  always @(posedge clk) begin
    cyc <= cyc + 1;
    if (cyc == 90000) begin
      failures++;
      give_verdict();
    end
  end
endmodule : tb
